// ===== mst_pkg.sv
// Constants shared by the module management status timing block.
package mst_pkg;
    // Clock and timing.
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned T_INIT_MS = 2000;
    localparam int unsigned INIT_MAX_CYC = T_INIT_MS * CLK_KHZ;
    localparam int unsigned T_RST_MIN_US = 2;
    localparam int unsigned RST_MIN_CYC = (T_RST_MIN_US * CLK_KHZ + 999) / 1000;
    // Register byte offsets.
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_RAW = 8'h10;
    // Status bit positions.
    localparam int STS_NOT_READY = 0;
    localparam int STS_BUS_READY = 1;
    localparam int STS_LOW_POWER = 2;
    localparam int STS_SELECTED = 3;
    // Flag layout: lane loss of signal, lane transmit fault, other, init done.
    localparam int N_LANE = 4;
    localparam int N_OTHER = 8;
    localparam int FLG_LOS = 0;
    localparam int FLG_TXF = 4;
    localparam int FLG_OTH = 8;
    localparam int FLG_INIT = 16;
    localparam int N_FLAG = 17;
    localparam int N_COND = 16;
    // Control bit positions and reset values.
    localparam int CTL_PDOWN = 0;
    localparam logic [N_FLAG-1:0] MASK_RST = 17'h00000;
    localparam logic CTL_PDOWN_RST = 1'b0;
    // Pin synchroniser layout.
    localparam int PIN_PWR = 20;
    localparam int PIN_RST = 19;
    localparam int PIN_SEL = 18;
    localparam int PIN_LP = 17;
    localparam int PIN_MCLK = 16;
    localparam int N_PIN = 21;
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_HOLD = 4'h2,
        ST_INIT = 4'h4,
        ST_READY = 4'h8
    } mst_state_t;
    typedef enum logic [2:0] {
        SEL_STATUS,
        SEL_FLAGS,
        SEL_MASK,
        SEL_CTRL,
        SEL_RAW,
        SEL_NONE
    } mst_sel_t;
endpackage : mst_pkg

// ===== mst_top.sv
// Module management control, status, flag latching and interrupt sequencing.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module mst_top
    import mst_pkg::*;
#(
    parameter int unsigned INIT_CYC = INIT_MAX_CYC
)(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus, write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Register bus, read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Module pins.
    input wire logic power_good,
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_select,
    input wire logic mgmt_clk,
    output logic interrupt_request_n,
    output logic low_power_mode,
    // Monitored conditions.
    input wire logic [N_LANE-1:0] rx_los,
    input wire logic [N_LANE-1:0] tx_fault,
    input wire logic [N_OTHER-1:0] other_cond
);

    if (INIT_CYC < 2 || INIT_CYC > INIT_MAX_CYC)
    begin : g_bad_init
        $error("INIT_CYC out of range");
    end

    function automatic mst_sel_t reg_sel(input logic [7:0] addr);
        unique case (addr)
            OFS_STATUS: reg_sel = SEL_STATUS;
            OFS_FLAGS: reg_sel = SEL_FLAGS;
            OFS_MASK: reg_sel = SEL_MASK;
            OFS_CTRL: reg_sel = SEL_CTRL;
            OFS_RAW: reg_sel = SEL_RAW;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction : reg_sel

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is read.
    logic [N_PIN-1:0] pin_s1_ff;
    logic [N_PIN-1:0] pin_s2_ff;
    logic mclk_d_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            mclk_d_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= {power_good, module_reset_n, module_select_n, low_power_select,
                          mgmt_clk, other_cond, tx_fault, rx_los};
            pin_s2_ff <= pin_s1_ff;
            mclk_d_ff <= pin_s2_ff[PIN_MCLK];
        end
    end

    logic pwr_s;
    logic rst_s;
    logic sel_s;
    logic lp_s;
    logic link_fall;
    logic [N_COND-1:0] cond_s;
    assign pwr_s = pin_s2_ff[PIN_PWR];
    assign rst_s = pin_s2_ff[PIN_RST];
    assign sel_s = ~pin_s2_ff[PIN_SEL];
    assign lp_s = pin_s2_ff[PIN_LP];
    assign cond_s = pin_s2_ff[N_COND-1:0];
    // Stand-in for the falling clock edge after a stop bit on the management link.
    assign link_fall = mclk_d_ff & ~pin_s2_ff[PIN_MCLK];

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse filter and initialization sequencer.
    localparam int RW = $clog2(RST_MIN_CYC + 1);
    localparam logic [RW-1:0] RST_LAST = RW'(RST_MIN_CYC - 1);
    localparam logic [31:0] INIT_LAST = 32'(INIT_CYC - 1);
    mst_state_t st_ff;
    logic [RW-1:0] rst_cnt_ff;
    logic [31:0] init_cnt_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || rst_s)
            rst_cnt_ff <= '0;
        else if (rst_cnt_ff != RST_LAST)
            rst_cnt_ff <= rst_cnt_ff + 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= ST_OFF;
            init_cnt_ff <= '0;
        end
        else if (!pwr_s)
        begin
            st_ff <= ST_OFF;
            init_cnt_ff <= '0;
        end
        else if (!rst_s && rst_cnt_ff == RST_LAST)
        begin
            st_ff <= ST_HOLD;
            init_cnt_ff <= '0;
        end
        else
        begin
            unique case (st_ff)
                ST_OFF: st_ff <= ST_INIT;
                ST_HOLD: if (rst_s) st_ff <= ST_INIT;
                ST_INIT:
                begin
                    init_cnt_ff <= init_cnt_ff + 32'h1;
                    if (init_cnt_ff == INIT_LAST)
                        st_ff <= ST_READY;
                end
                ST_READY: st_ff <= ST_READY;
            endcase
        end
    end

    logic ready;
    logic init_done;
    assign ready = (st_ff == ST_READY);
    assign init_done = (st_ff == ST_INIT) && (init_cnt_ff == INIT_LAST) && pwr_s &&
                       !(!rst_s && rst_cnt_ff == RST_LAST);

    // Accesses get OKAY only once ready and selected; the pin path adds two cycles, this flop one more.
    logic bus_on_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bus_on_ff <= 1'b0;
        else
            bus_on_ff <= ready && sel_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
                awaddr_ff <= s_axi_awaddr;
            if (w_hs)
            begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_held_ff <= wr_go ? 1'b0 : (aw_held_ff | aw_hs);
            w_held_ff <= wr_go ? 1'b0 : (w_held_ff | w_hs);
            s_axi_awready <= ~(aw_held_ff | aw_hs) & ~(s_axi_bvalid | wr_go);
            s_axi_wready <= ~(w_held_ff | w_hs) & ~(s_axi_bvalid | wr_go);
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                if (reg_sel(awaddr_ff) == SEL_NONE)
                    s_axi_bresp <= RESP_DECERR;
                else if (!bus_on_ff)
                    s_axi_bresp <= RESP_SLVERR;
                else
                    s_axi_bresp <= RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ok;
    assign wr_ok = wr_go && bus_on_ff && wstrb_ff[0];

    ////////////////////////////////////////////////////////////////////////////
    // Mask and power-down: written values wait for the next link falling edge.
    logic [N_FLAG-1:0] mask_wr_ff;
    logic [N_FLAG-1:0] mask_eff_ff;
    logic pdown_wr_ff;
    logic pdown_eff_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_wr_ff <= MASK_RST;
            pdown_wr_ff <= CTL_PDOWN_RST;
        end
        else if (wr_ok && reg_sel(awaddr_ff) == SEL_MASK)
            mask_wr_ff <= wdata_ff[N_FLAG-1:0];
        else if (wr_ok && reg_sel(awaddr_ff) == SEL_CTRL)
            pdown_wr_ff <= wdata_ff[CTL_PDOWN];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_eff_ff <= MASK_RST;
            pdown_eff_ff <= CTL_PDOWN_RST;
        end
        else if (link_fall)
        begin
            mask_eff_ff <= mask_wr_ff;
            pdown_eff_ff <= pdown_wr_ff;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            low_power_mode <= 1'b0;
        else
            low_power_mode <= lp_s | pdown_eff_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latched flags with clear on read; a new event wins over a pending clear.
    logic [N_FLAG-1:0] flags_ff;
    logic [N_FLAG-1:0] clr_pend_ff;
    logic [N_FLAG-1:0] flag_set;
    logic rd_flags;
    assign flag_set = {init_done, cond_s};
    assign rd_flags = ar_hs && bus_on_ff && reg_sel(s_axi_araddr) == SEL_FLAGS;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clr_pend_ff <= '0;
        else if (link_fall)
            clr_pend_ff <= rd_flags ? flags_ff : '0;
        else if (rd_flags)
            clr_pend_ff <= clr_pend_ff | flags_ff;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_ff <= '0;
        else if (link_fall)
            flags_ff <= (flags_ff & ~clr_pend_ff) | flag_set;
        else
            flags_ff <= flags_ff | flag_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            interrupt_request_n <= 1'b1;
        else
            interrupt_request_n <= ~|(flags_ff & ~mask_eff_ff);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel.
    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = '0;
        unique case (reg_sel(s_axi_araddr))
            SEL_STATUS:
            begin
                rd_word[STS_NOT_READY] = ~ready;
                rd_word[STS_BUS_READY] = ready;
                rd_word[STS_LOW_POWER] = low_power_mode;
                rd_word[STS_SELECTED] = sel_s;
            end
            SEL_FLAGS: rd_word[N_FLAG-1:0] = flags_ff;
            SEL_MASK: rd_word[N_FLAG-1:0] = mask_wr_ff;
            SEL_CTRL: rd_word[CTL_PDOWN] = pdown_wr_ff;
            SEL_RAW: rd_word[N_COND-1:0] = cond_s;
            SEL_NONE: rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~(ar_hs | s_axi_rvalid);
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                if (reg_sel(s_axi_araddr) == SEL_NONE)
                begin
                    s_axi_rresp <= RESP_DECERR;
                    s_axi_rdata <= '0;
                end
                else if (!bus_on_ff)
                begin
                    s_axi_rresp <= RESP_SLVERR;
                    s_axi_rdata <= '0;
                end
                else
                begin
                    s_axi_rresp <= RESP_OKAY;
                    s_axi_rdata <= rd_word;
                end
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_irq_on;
        (|(flags_ff & ~mask_eff_ff)) |=> !interrupt_request_n;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not asserted");
    property p_irq_off;
        !(|(flags_ff & ~mask_eff_ff)) |=> interrupt_request_n;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not released");
    property p_los;
        |cond_s[FLG_LOS+:N_LANE] |=> (flags_ff[FLG_LOS+:N_LANE] & $past(cond_s[FLG_LOS+:N_LANE]))
            == $past(cond_s[FLG_LOS+:N_LANE]);
    endproperty
    a_los: assert property (p_los) else $error("los flag missed");
    property p_txf;
        |cond_s[FLG_TXF+:N_LANE] |=> flags_ff[FLG_TXF+:N_LANE] != '0;
    endproperty
    a_txf: assert property (p_txf) else $error("tx fault flag missed");
    property p_other;
        cond_s[FLG_OTH] && !mask_eff_ff[FLG_OTH] |-> ##[1:2] !interrupt_request_n;
    endproperty
    a_other: assert property (p_other) else $error("other flag no irq");
    property p_rst_min;
        (st_ff != ST_HOLD) ##1 (st_ff == ST_HOLD) |-> $past(rst_cnt_ff) == RST_LAST;
    endproperty
    a_rst_min: assert property (p_rst_min) else $error("short reset accepted");
    property p_init_end;
        init_done |=> ready && flags_ff[FLG_INIT];
    endproperty
    a_init_end: assert property (p_init_end) else $error("init end wrong");
    property p_refuse;
        ar_hs && !bus_on_ff && reg_sel(s_axi_araddr) != SEL_NONE |=> s_axi_rresp == RESP_SLVERR;
    endproperty
    a_refuse: assert property (p_refuse) else $error("deselected read answered");
    property p_lp;
        lp_s || pdown_eff_ff |=> low_power_mode;
    endproperty
    a_lp: assert property (p_lp) else $error("low power missed");
    property p_mask_apply;
        link_fall |=> mask_eff_ff == $past(mask_wr_ff) && pdown_eff_ff == $past(pdown_wr_ff);
    endproperty
    a_mask_apply: assert property (p_mask_apply) else $error("mask not applied");

    c_init: cover property (init_done ##1 !interrupt_request_n);
    c_los: cover property (cond_s[FLG_LOS] ##[1:3] !interrupt_request_n);
    c_clear: cover property (rd_flags ##[1:200] interrupt_request_n);
    c_pdown: cover property ($rose(pdown_eff_ff) ##1 low_power_mode);

endmodule : mst_top

// ===== mst_host_model.sv
// Host-side pin model: supply, reset, select and low-power pins, link clock frames.
`timescale 1ns/1ps
module mst_host_model (
    // Host pins.
    output logic power_good,
    output logic module_reset_n,
    output logic module_select_n,
    output logic low_power_select,
    // Link clock.
    output logic mgmt_clk
);
    initial
    begin
        power_good = 1'b0;
        module_reset_n = 1'b1;
        module_select_n = 1'b1;
        low_power_select = 1'b0;
        mgmt_clk = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // supply, select and low-power levels
    task automatic drive(input logic pg, input logic sel_n, input logic lp);
        power_good <= pg;
        module_select_n <= sel_n;
        low_power_select <= lp;
    endtask : drive

    task automatic reset_pulse(input int width_ns);
        module_reset_n <= 1'b0;
        #(width_ns);
        module_reset_n <= 1'b1;
    endtask : reset_pulse

    // falling edges after a transfer
    // The clock idles high between frames, so pending writes wait for the next frame.
    task automatic clock_frame();
        repeat (3)
        begin
            #100 mgmt_clk <= 1'b0;
            #100 mgmt_clk <= 1'b1;
        end
    endtask : clock_frame
endmodule : mst_host_model

// ===== tb_mst_top.sv
// Self-checking bench for the module management status timing block.
`timescale 1ns/1ps
module tb_mst_top
    import mst_pkg::*;
;
    localparam logic [31:0] STS_RDY = (32'h1 << STS_BUS_READY) | (32'h1 << STS_SELECTED);
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic pg, rst_n, sel_n, lp, mclk, irq_n, lpm;
    logic [N_COND-1:0] cond;
    int errors;
    int total_checks;
    logic [33:0] rq[$];
    logic [1:0] bq[$];

    mst_top #(.INIT_CYC(20)) mst_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .power_good(pg), .module_reset_n(rst_n), .module_select_n(sel_n),
        .low_power_select(lp), .mgmt_clk(mclk), .interrupt_request_n(irq_n),
        .low_power_mode(lpm), .rx_los(cond[3:0]), .tx_fault(cond[7:4]),
        .other_cond(cond[15:8])
    );
    mst_host_model host_inst (
        .power_good(pg), .module_reset_n(rst_n), .module_select_n(sel_n),
        .low_power_select(lp), .mgmt_clk(mclk)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic pin(input logic seen, input logic exp);
        check({33'h0, seen}, {33'h0, exp});
    endtask : pin

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_cyc

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 1'b0;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            done = bvalid;
        end
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 1'b0;
        rq.push_back({r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            done = rvalid;
        end
        rready <= 1'b0;
    endtask : axi_read

    // Reads the flags, lets one link frame commit the clear, then looks at the line.
    task automatic clear_flags(input logic [31:0] exp, input logic irq_exp);
        axi_read(OFS_FLAGS, exp, RESP_OKAY);
        host_inst.clock_frame();
        wait_cyc(4);
        pin(irq_n, irq_exp);
    endtask : clear_flags

    task automatic init_done();
        wait_cyc(40);
        pin(irq_n, 1'b0);
        axi_read(OFS_STATUS, STS_RDY, RESP_OKAY);
        clear_flags(32'h1 << FLG_INIT, 1'b1);
    endtask : init_done

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, errors);
    endtask : end_test

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Results are compared in the order the drivers noted them.
    always @(posedge aclk)
    begin
        if (rvalid && rready && rq.size() > 0)
            check({rresp, rdata}, rq.pop_front());
        if (bvalid && bready && bq.size() > 0)
            check({32'h0, bresp}, {32'h0, bq.pop_front()});
    end

    initial
    begin
        wait_cyc(20000);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial
    begin
        int b;
        int base[3];
        int width[3];
        base = '{FLG_LOS, FLG_TXF, FLG_OTH};
        width = '{N_LANE, N_LANE, N_OTHER};
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        cond = '0;
        errors = 0;
        total_checks = 0;
        void'($urandom(32'hce2c));
        host_inst.drive(1'b0, 1'b0, 1'b0);
        wait_cyc(12);
        aresetn <= 1'b1;
        wait_cyc(2);
        axi_read(OFS_STATUS, 32'h0, RESP_SLVERR);
        pin(irq_n, 1'b1);
        host_inst.drive(1'b1, 1'b0, 1'b0);
        init_done();
        end_test("power on");
        for (int k = 0; k < 3; k++)
        begin
            b = base[k] + int'($urandom % width[k]);
            @(posedge aclk);
            cond[b] <= 1'b1;
            wait_cyc(8);
            pin(irq_n, 1'b0);
            axi_read(OFS_RAW, 32'h1 << b, RESP_OKAY);
            clear_flags(32'h1 << b, 1'b0);
            cond[b] <= 1'b0;
            clear_flags(32'h1 << b, 1'b1);
        end
        end_test("flags");
        b = int'($urandom % N_LANE);
        axi_write(OFS_MASK, 32'h1 << b, RESP_OKAY);
        host_inst.clock_frame();
        cond[b] <= 1'b1;
        wait_cyc(8);
        pin(irq_n, 1'b1);
        axi_read(OFS_MASK, 32'h1 << b, RESP_OKAY);
        cond[b] <= 1'b0;
        axi_write(OFS_MASK, 32'h0, RESP_OKAY);
        wait_cyc(6);
        pin(irq_n, 1'b1);
        host_inst.clock_frame();
        wait_cyc(4);
        pin(irq_n, 1'b0);
        clear_flags(32'h1 << b, 1'b1);
        end_test("mask");
        axi_write(OFS_CTRL, 32'h1 << CTL_PDOWN, RESP_OKAY);
        wait_cyc(6);
        pin(lpm, 1'b0);
        host_inst.clock_frame();
        wait_cyc(4);
        pin(lpm, 1'b1);
        axi_read(OFS_STATUS, STS_RDY | (32'h1 << STS_LOW_POWER), RESP_OKAY);
        axi_write(OFS_CTRL, 32'h0, RESP_OKAY);
        host_inst.clock_frame();
        wait_cyc(4);
        pin(lpm, 1'b0);
        host_inst.drive(1'b1, 1'b0, 1'b1);
        wait_cyc(6);
        pin(lpm, 1'b1);
        host_inst.drive(1'b1, 1'b0, 1'b0);
        wait_cyc(6);
        pin(lpm, 1'b0);
        end_test("power level");
        // The host keeps off the bus for the full deselect time before probing.
        host_inst.drive(1'b1, 1'b1, 1'b0);
        wait_cyc(4000);
        axi_read(OFS_STATUS, 32'h0, RESP_SLVERR);
        axi_write(OFS_MASK, 32'h1ffff, RESP_SLVERR);
        host_inst.drive(1'b1, 1'b0, 1'b0);
        wait_cyc(10);
        axi_read(OFS_MASK, 32'h0, RESP_OKAY);
        axi_read(8'h14, 32'h0, RESP_DECERR);
        axi_write(8'h14, $urandom, RESP_DECERR);
        end_test("select");
        host_inst.reset_pulse(1000);
        wait_cyc(10);
        axi_read(OFS_STATUS, STS_RDY, RESP_OKAY);
        host_inst.reset_pulse(3000);
        axi_read(OFS_STATUS, 32'h0, RESP_SLVERR);
        init_done();
        host_inst.drive(1'b0, 1'b0, 1'b0);
        wait_cyc(10);
        axi_read(OFS_STATUS, 32'h0, RESP_SLVERR);
        host_inst.drive(1'b1, 1'b0, 1'b0);
        init_done();
        end_test("reset");
        print_verdict();
    end
endmodule : tb_mst_top
